// ---- hdl/sdt_consts.vh ----
/*
 Constants for the scan doubler timing generator.
 Assumes a single 100 MHz system clock; no registers reach software.
*/
`ifndef SDT_CONSTS_VH
`define SDT_CONSTS_VH

// Line divider modulus on the inbound sample rate
`define SDT_LINE_MODULUS   455
`define SDT_LINE_CNT_W     9
// System clock period in ps and octal sample clock period in ps
`define SDT_SYS_PERIOD_PS  10000
`define SDT_OCTAL_PER_PS   35000
// Octal clock half period in system cycles, rounded down; sdt_timing floors it at one
`define SDT_OCTAL_HALF_CYC ((`SDT_OCTAL_PER_PS / 2) / `SDT_SYS_PERIOD_PS)
`define SDT_DIV_W          4
// Reset values
`define SDT_CNT_RST        9'h000

`endif

// ---- hdl/sdt_sync_pulse.v ----
/*
 Two-stage synchroniser with a rising-edge pulse output one enable
 period long, sampled on an enable. Assumes enable pulses come from
 the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sdt_sync_pulse (
   // Clock and reset
   input  wire clk,
   input  wire rst_n,
   input  wire en,
   // Level in, pulse out
   input  wire din,
   output reg  pulse
);
   reg stage1;
   reg stage2;
   reg stage3;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         pulse  <= 1'b0;
      end else if (en) begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         // Edge taken from stage2 so stage1 stays clean
         pulse  <= stage2 & ~stage3;
      end
      // Pulse stands until the next enable, so that enable's edge sees it
   end
endmodule // sdt_sync_pulse
`default_nettype wire

// ---- hdl/sdt_timing.v ----
/*
 Scan doubler timing generator: sample clocks, line buffer pointer
 restarts, composite sync and PLL horizontal reference.
 Both sample clocks are divided down from clk and leave as registered
 levels; each has a one-cycle tick on its rising edge, so all other
 logic stays on clk alone. Their rate follows HALF_CYC, so at the
 default system clock they run faster than true subcarrier rates.
 Assumes vsync_wide is already width adjusted and synchronous to clk.
 Assumes the buffer and the phase comparator take the restarts on
 the rising edges of the sample clocks that this block drives.
*/
`include "sdt_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module sdt_timing #(
   parameter MODULUS  = `SDT_LINE_MODULUS,
   parameter HALF_CYC = `SDT_OCTAL_HALF_CYC
) (
   // Clock and reset
   input  wire clk,
   input  wire rst_n,
   // Sync input
   input  wire vsync_wide,
   // Line buffer clocks
   output reg  octal_subcarrier_clock,
   output reg  quad_subcarrier_clock,
   // Line buffer restarts
   output reg  line_write_restart,
   output reg  line_read_restart,
   // Display and PLL
   output reg  double_line_rate_pulse,
   output reg  composite_sync,
   output reg  pll_h_reference
);
   reg                       rst_s1;
   reg                       rst_s2;
   reg [`SDT_DIV_W-1:0]      div_cnt;
   reg                       octal_rise;
   reg                       quad_rise;
   reg [`SDT_LINE_CNT_W-1:0] line_cnt;
   reg                       half_tgl;
   reg                       vs_held;
   wire                      rd_pulse;
   wire                      wr_pulse;
   // Next values, divider side
   reg [`SDT_DIV_W-1:0]      next_div_cnt;
   reg                       next_octal;
   reg                       next_octal_rise;
   reg                       next_quad;
   reg                       next_quad_rise;
   // Next values, line side
   reg [`SDT_LINE_CNT_W-1:0] next_line_cnt;
   reg                       next_dbl;
   reg                       next_half_tgl;
   // Next values, output side
   reg                       next_rd_restart;
   reg                       next_wr_restart;
   reg                       next_reference;
   reg                       next_vs_held;
   reg                       next_csync;
   // Terminal counts, cut to counter width on purpose
   wire [`SDT_DIV_W-1:0]     half_last;
   wire [`SDT_LINE_CNT_W-1:0] line_last;

   // A zero half period would wrap the terminal count to 15; floor it at one
   localparam HALF_EFF = (HALF_CYC < 1) ? 1 : HALF_CYC;
   assign half_last = HALF_EFF[`SDT_DIV_W-1:0] - 4'h1;
   assign line_last = MODULUS[`SDT_LINE_CNT_W-1:0] - 9'h001;

   // Reset release through two flops
   // Retimed release lets every counter leave reset on one edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   // Octal clock from divider; quad is octal halved, so both in phase
   always @* begin
      next_div_cnt    = div_cnt + 4'h1;
      next_octal      = octal_subcarrier_clock;
      next_octal_rise = 1'b0;
      if (div_cnt == half_last) begin
         next_div_cnt    = {`SDT_DIV_W{1'b0}};
         next_octal      = ~octal_subcarrier_clock;
         next_octal_rise = ~octal_subcarrier_clock;
      end
   end

   // Quad toggles on each octal rise
   always @* begin
      next_quad      = quad_subcarrier_clock;
      next_quad_rise = 1'b0;
      if (next_octal_rise) begin
         next_quad      = ~quad_subcarrier_clock;
         // Buffer takes a sample on each quad rise
         next_quad_rise = ~quad_subcarrier_clock;
      end
   end

   // Divider state
   always @(posedge clk or negedge rst_s2) begin
      if (!rst_s2) begin
         div_cnt                <= {`SDT_DIV_W{1'b0}};
         octal_subcarrier_clock <= 1'b0;
         quad_subcarrier_clock  <= 1'b0;
         octal_rise             <= 1'b0;
         quad_rise              <= 1'b0;
      end else begin
         div_cnt                <= next_div_cnt;
         octal_subcarrier_clock <= next_octal;
         quad_subcarrier_clock  <= next_quad;
         octal_rise             <= next_octal_rise;
         quad_rise              <= next_quad_rise;
      end
   end

   // Line divider on inbound sample rate
   always @* begin
      next_line_cnt = line_cnt;
      next_dbl      = double_line_rate_pulse;
      next_half_tgl = half_tgl;
      if (quad_rise) begin
         if (line_cnt == line_last) begin
            next_line_cnt = `SDT_CNT_RST;
            // Pulse stands one quad period, one written sample wide
            next_dbl      = 1'b1;
            next_half_tgl = ~half_tgl;
         end else begin
            next_line_cnt = line_cnt + 9'h001;
            next_dbl      = 1'b0;
         end
      end
   end

   // Line state moves only on quad ticks
   always @(posedge clk or negedge rst_s2) begin
      if (!rst_s2) begin
         line_cnt               <= `SDT_CNT_RST;
         double_line_rate_pulse <= 1'b0;
         half_tgl               <= 1'b0;
      end else begin
         line_cnt               <= next_line_cnt;
         double_line_rate_pulse <= next_dbl;
         half_tgl               <= next_half_tgl;
      end
   end

   // Read restart, seen on outbound clock edges
   // Two stages cost lag but keep the first flop out of the logic
   sdt_sync_pulse u_rd_sync (
      .clk   (clk),
      .rst_n (rst_s2),
      .en    (octal_rise),
      .din   (double_line_rate_pulse),
      .pulse (rd_pulse)
   );

   // Write restart from halved line rate
   // Halved rate crosses as a level, so no edge can be lost
   sdt_sync_pulse u_wr_sync (
      .clk   (clk),
      .rst_n (rst_s2),
      .en    (quad_rise),
      .din   (half_tgl),
      .pulse (wr_pulse)
   );

   // Restarts held across one sample clock period so buffer sees a rise
   always @* begin
      next_rd_restart = line_read_restart;
      next_wr_restart = line_write_restart;
      next_reference  = pll_h_reference;
      next_vs_held    = vs_held;
      if (octal_rise) begin
         next_rd_restart = rd_pulse;
      end
      if (quad_rise) begin
         next_wr_restart = wr_pulse;
         // Reference is the write restart, so loop locks to buffer lines
         next_reference  = wr_pulse;
      end
      // Vsync caught on the doubled pulse, then merged
      if (quad_rise && double_line_rate_pulse) begin
         next_vs_held = vsync_wide;
      end
      // XOR inverts the pulse while vsync is held high
      next_csync = vs_held ^ double_line_rate_pulse;
   end

   // Every output leaves a flop, so the buffer sees no glitch
   always @(posedge clk or negedge rst_s2) begin
      if (!rst_s2) begin
         line_read_restart  <= 1'b0;
         line_write_restart <= 1'b0;
         pll_h_reference    <= 1'b0;
         vs_held            <= 1'b0;
         composite_sync     <= 1'b0;
      end else begin
         line_read_restart  <= next_rd_restart;
         line_write_restart <= next_wr_restart;
         pll_h_reference    <= next_reference;
         vs_held            <= next_vs_held;
         composite_sync     <= next_csync;
      end
   end
endmodule // sdt_timing
`default_nettype wire

// ---- testbench/sdt_timing_properties.sv ----
/* Checker on sdt_timing ports.
   Assumes one clock and a low reset. */
`timescale 1ns/1ps
`default_nettype none
module sdt_chk #(parameter int MODULUS = 5, parameter int HALF = 1) (
   input wire logic clk, rst_n, vsync_wide, octal_subcarrier_clock,
   input wire logic quad_subcarrier_clock, line_write_restart,
   input wire logic line_read_restart, double_line_rate_pulse,
   input wire logic composite_sync, pll_h_reference
);
   localparam int OPER = 2 * HALF;
   localparam int PER = 4 * HALF * MODULUS;
   localparam int PER2 = 8 * HALF * MODULUS;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Read restart high one octal period, write restart one quad period
   sequence rd_one; line_read_restart[*2] ##1 !line_read_restart; endsequence
   sequence wr_one; line_write_restart[*4] ##1 !line_write_restart; endsequence
   pll_ref_a: assert property (pll_h_reference == line_write_restart)
      else $error("reference differs");
   quad_rate_a: assert property ($rose(quad_subcarrier_clock)
      |=> quad_subcarrier_clock ##1 !quad_subcarrier_clock) else $error("quad");
   octal_per_a: assert property ($rose(octal_subcarrier_clock)
      |-> ##OPER $rose(octal_subcarrier_clock)) else $error("octal period");
   quad_phase_a: assert property ($rose(quad_subcarrier_clock)
      |-> $rose(octal_subcarrier_clock)) else $error("quad phase");
   line_per_a: assert property ($rose(double_line_rate_pulse)
      |-> ##PER $rose(double_line_rate_pulse)) else $error("line period");
   rd_follow_a: assert property ($rose(double_line_rate_pulse)
      |-> ##[1:10] $rose(line_read_restart)) else $error("read late");
   rd_width_a: assert property ($rose(line_read_restart) |-> rd_one)
      else $error("read width");
   wr_width_a: assert property ($rose(line_write_restart) |-> wr_one)
      else $error("write width");
   wr_per_a: assert property ($rose(line_write_restart)
      |-> ##PER2 $rose(line_write_restart)) else $error("write period");
   sync_src_a: assert property ($changed(composite_sync) |->
      ($past(double_line_rate_pulse) || $past(double_line_rate_pulse, 2)))
      else $error("sync moved alone");
endmodule // sdt_chk
bind sdt_timing sdt_chk #(.MODULUS(MODULUS), .HALF(HALF_CYC)) sdt_chk_i (.*);
`default_nettype wire

// ---- testbench/sdt_line_buf.sv ----
/* Line buffer model. Assumes write enable held active. */
`timescale 1ns/1ps
`default_nettype none
module sdt_line_buf #(parameter int DEPTH = 10) (
   input wire logic inbound_sample_clock, wrst, outbound_sample_clock, rrst,
   input wire logic [7:0] din,
   output logic [7:0] dout
);
   logic [7:0] mem [DEPTH];
   int wp = 3; // Power-up pointers left arbitrary
   int rp = 7;
   always @(posedge inbound_sample_clock) begin
      if (wrst) wp <= 0;
      else begin
         mem[wp] <= din;
         wp <= (wp == DEPTH - 1) ? 0 : wp + 1;
      end
   end
   always @(posedge outbound_sample_clock) begin
      if (rrst) rp <= 0;
      else begin
         dout <= mem[rp];
         rp <= (rp == DEPTH - 1) ? 0 : rp + 1;
      end
   end
endmodule // sdt_line_buf
`default_nettype wire

// ---- testbench/tb_top.sv ----
/* Bench for sdt_timing. Assumes a 100 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int MOD = 5;
   localparam int W = 16 * MOD;
   logic clk = 0, rst_n = 0, vsync_wide = 0;
   logic [7:0] din = 8'h5a;
   wire oc, qc, wr, rd, dbl, cs, rf;
   wire [7:0] dout;
   int fail_count = 0, checks_done = 0;
   typedef struct {logic vs; int hi;} row_t;
   row_t rows[2] = '{'{1'b0, W / MOD}, '{1'b1, W - W / MOD}};
   always #5 clk = ~clk;
   sdt_timing #(.MODULUS(MOD)) sdt_timing_i (.clk(clk), .rst_n(rst_n),
      .vsync_wide(vsync_wide), .octal_subcarrier_clock(oc),
      .quad_subcarrier_clock(qc), .line_write_restart(wr),
      .line_read_restart(rd), .double_line_rate_pulse(dbl),
      .composite_sync(cs), .pll_h_reference(rf));
   sdt_line_buf #(.DEPTH(2 * MOD)) sdt_line_buf_i (.inbound_sample_clock(qc), .wrst(wr),
      .outbound_sample_clock(oc), .rrst(rd), .din(din), .dout(dout));
   task chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task results;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Whole run is near 384 cycles
   initial begin
      #20000 fail_count++;
      results();
   end
   initial begin
      int nd, nr, nw, nh, no, nq, nf;
      repeat (2) @(negedge clk);
      chk(dbl === 1'b0 && wr === 1'b0 && cs === 1'b0, "reset");
      rst_n = 1;
      foreach (rows[i]) begin
         vsync_wide = rows[i].vs;
         repeat (60) @(negedge clk);
         nd = 0; nr = 0; nw = 0; nh = 0;
         no = 0; nq = 0; nf = 0;
         repeat (W) begin
            @(negedge clk);
            nd += dbl; nr += rd; nw += wr; nh += cs;
            no += oc; nq += qc; nf += rf;
         end
         chk(nd == W / MOD && nr == W / (2 * MOD), "line rate");
         chk(nw == W / (2 * MOD) && rf === wr, "write restart");
         chk(nh == rows[i].hi, "composite sync");
         chk(no == W / 2 && nq == W / 2, "sample clocks");
         chk(nf == nw, "reference");
      end
      chk(dout === 8'h5a, "buffer data");
      rst_n = 0;
      #1 chk(dbl === 1'b0 && rd === 1'b0 && qc === 1'b0, "async reset");
      repeat (2) @(negedge clk);
      rst_n = 1;
      repeat (2) @(negedge clk);
      chk(oc === 1'b0 && qc === 1'b0, "held after release");
      @(negedge clk);
      chk(oc === 1'b1 && qc === 1'b1, "first sample edge");
      repeat (97) @(negedge clk);
      results();
   end
endmodule // tb_top
`default_nettype wire
